// ---- inc/cpl_params_params.svh ----
// Register offsets, field positions, reset values and timing figures of the charger pin logic.
`ifndef CPL_PARAMS_PARAMS_SVH
`define CPL_PARAMS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CPL_ADDR_INPUT_SOURCE 3'h0
`define CPL_ADDR_CONTROL_1    3'h1
`define CPL_ADDR_INT_STATUS   3'h2
`define CPL_ADDR_INT_MASK     3'h3
`define CPL_ADDR_SHIP_CTRL    3'h4
`define CPL_ADDR_STATE        3'h5

// ****************************************
// Field positions and codes
// ****************************************
`define CPL_LIM_HI       2
`define CPL_LIM_LO       0
`define CPL_BOOST_BIT    5
`define CPL_CFG_HI       5
`define CPL_CFG_LO       4
`define CPL_CFG_CHARGE   2'h1
`define CPL_SHIP_REQ_BIT 0
`define CPL_LIM_100MA    3'h0
`define CPL_LIM_500MA    3'h2
`define CPL_INT_CHG      0
`define CPL_INT_FAULT    1
`define CPL_INT_SHIP     2
`define CPL_INT_RESET    3
`define CPL_INT_BITS     4

// ****************************************
// Reset values
// ****************************************
`define CPL_RST_INPUT_SOURCE 8'h02
`define CPL_RST_CONTROL_1    8'h10
`define CPL_RST_INT_MASK     4'hF

// ****************************************
// Timing figures
// ****************************************
`define CPL_CLK_HZ                50000000
`define CPL_IRQ_PULSE_US          256
`define CPL_BLINK_HZ              1
`define CPL_SHIP_EXIT_DEGLITCH_MS 100
`define CPL_SYSTEM_RESET_HOLD_MS  10000
`define CPL_BATTERY_SWITCH_OFF_MS 500

`endif

// ---- inc/cpl_pkg.sv ----
// Types shared by the charger pin logic.
package cpl_pkg;

  // Battery switch sequencing states.
  typedef enum logic [1:0] {
    CPL_RUN       = 2'b00,
    CPL_SHIP      = 2'b01,
    CPL_RESET_OFF = 2'b10
  } cpl_ship_state_type;

endpackage

// ---- design/cpl_low_hold_timer.sv ----
// Counter that reports once when an active-low input has stayed low for a set number of cycles.
`timescale 1ns/1ns
module cpl_low_hold_timer
  import cpl_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 5000000
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic level_n,
  output logic      hold_done
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_hold_done;

  // ****************************************
  // Hold counter
  // ****************************************
  // The count saturates so one long press gives one report, and any high sample restarts it.
  always_comb begin
    next_cnt       = cnt;
    next_hold_done = 1'b0;
    if (level_n) begin
      next_cnt = '0;
    end else if (cnt != CW'(HOLD_CYCLES)) begin
      next_cnt       = cnt + CW'(1);
      next_hold_done = (cnt == CW'(HOLD_CYCLES - 1));
    end
  end

  // The count freezes while the clock enable is low; the report is cleared.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= '0;
      hold_done <= 1'b0;
    end else if (clk_en) begin
      cnt       <= next_cnt;
      hold_done <= next_hold_done;
    end else begin
      hold_done <= 1'b0;
    end
  end

endmodule

// ---- design/cpl_charger_pins.sv ----
// Pin control, register port and status outputs of the single-cell charger.
`timescale 1ns/1ns
// What this block does
// - Source select high means USB host port, low means wall adapter.
// - Input-good pin pulled low only while input is valid and limit above 30 mA.
// - Charge-status pin low while charging, released when done or disabled.
// - Any fault makes the charge-status pin blink at 1 Hz.
// - Status change or fault emits one 256 us low pulse on interrupt pin.
// - Buck with USB host: limit 500 mA if boost pin high, else 100 mA.
// - Boost mode only when control bit 5 set and boost pin high.
// - Charging only when control bits 5:4 equal 01 and enable pin low.
// - Effective input limit is the lower of the pin-derived (USB host or resistor) and register limits.
// - Resistor-derived limit is never below 500 mA.
// - Thermistor out of range suspends charging and disables boost.
// - Ship-exit pin low past deglitch time turns battery switch on.
// - Without input, long ship-exit press turns switch off for off time.
`include "cpl_params_params.svh"
module cpl_charger_pins
  import cpl_pkg::*;
#(
  parameter int unsigned IRQ_PULSE_CYCLES  = (`CPL_CLK_HZ / 1000000) * `CPL_IRQ_PULSE_US,
  parameter int unsigned BLINK_HALF_CYCLES = `CPL_CLK_HZ / (2 * `CPL_BLINK_HZ),
  parameter int unsigned DEGLITCH_CYCLES   = (`CPL_CLK_HZ / 1000) * `CPL_SHIP_EXIT_DEGLITCH_MS,
  parameter int unsigned RESET_HOLD_CYCLES = (`CPL_CLK_HZ / 1000) * `CPL_SYSTEM_RESET_HOLD_MS,
  parameter int unsigned RESET_OFF_CYCLES  = (`CPL_CLK_HZ / 1000) * `CPL_BATTERY_SWITCH_OFF_MS
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       source_is_usb_host,
  input  wire logic       boost_request_pin,
  input  wire logic       charge_enable_n,
  input  wire logic [2:0] input_limit_resistor_pin,
  input  wire logic       input_in_window,
  input  wire logic       input_above_sleep,
  input  wire logic       input_present,
  input  wire logic       thermistor_sense_fault,
  input  wire logic       charge_complete,
  input  wire logic       fault_present,
  input  wire logic       ship_exit_button_n,
  output logic            input_good_n_oe,
  output logic            charge_status_n_oe,
  output logic            interrupt_n_oe,
  output logic            irq,
  output logic            charge_enable,
  output logic            boost_enable,
  output logic      [2:0] input_current_limit,
  output logic            battery_switch_on
);

  localparam int unsigned PW = $clog2(IRQ_PULSE_CYCLES + 1);
  localparam int unsigned BW = $clog2(BLINK_HALF_CYCLES + 1);
  localparam int unsigned OW = $clog2(RESET_OFF_CYCLES + 1);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]              input_source_register;
  logic [7:0]              control_register_1;
  logic [`CPL_INT_BITS-1:0] int_status;
  logic [`CPL_INT_BITS-1:0] int_mask;
  logic [7:0]              next_src;
  logic [7:0]              next_ctl1;
  logic [`CPL_INT_BITS-1:0] next_status;
  logic [`CPL_INT_BITS-1:0] next_mask;
  logic [`CPL_INT_BITS-1:0] events;
  logic [7:0]              next_rdata;
  logic                    next_irq;
  logic                    ship_req;
  cpl_ship_state_type      ship_state;
  logic [PW-1:0]           pulse_cnt;
  logic                    blink_phase;
  logic                    exit_done;
  logic                    hold_done;

  // Writes store, a status read returns the flags and clears them, and a new event wins over that clear.
  always_comb begin
    next_src    = input_source_register;
    next_ctl1   = control_register_1;
    next_mask   = int_mask;
    next_status = int_status;
    ship_req    = 1'b0;
    next_rdata  = 8'h00;
    if (reg_write) begin
      unique case (reg_addr)
        `CPL_ADDR_INPUT_SOURCE: next_src  = reg_wdata;
        `CPL_ADDR_CONTROL_1:    next_ctl1 = reg_wdata;
        `CPL_ADDR_INT_MASK:     next_mask = reg_wdata[`CPL_INT_BITS-1:0];
        `CPL_ADDR_SHIP_CTRL:    ship_req  = reg_wdata[`CPL_SHIP_REQ_BIT];
        default:                ship_req  = 1'b0;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        `CPL_ADDR_INPUT_SOURCE: next_rdata = input_source_register;
        `CPL_ADDR_CONTROL_1:    next_rdata = control_register_1;
        `CPL_ADDR_INT_STATUS:   next_rdata = {4'h0, int_status};
        `CPL_ADDR_INT_MASK:     next_rdata = {4'h0, int_mask};
        `CPL_ADDR_STATE:        next_rdata = {1'b0, boost_enable, charge_enable, charge_status_n_oe,
                                              input_good_n_oe, battery_switch_on, ship_state};
        default:                next_rdata = 8'h00;
      endcase
      if (reg_addr == `CPL_ADDR_INT_STATUS) begin
        next_status = '0;
      end
    end
    next_status = next_status | events;
    next_irq    = |(next_status & next_mask);
  end

  // Register stage; all state freezes while the clock enable is low.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_source_register <= `CPL_RST_INPUT_SOURCE;
      control_register_1    <= `CPL_RST_CONTROL_1;
      int_status            <= '0;
      int_mask              <= `CPL_RST_INT_MASK;
      reg_rdata             <= 8'h00;
      irq                   <= 1'b0;
    end else if (clk_en) begin
      input_source_register <= next_src;
      control_register_1    <= next_ctl1;
      int_status            <= next_status;
      int_mask              <= next_mask;
      reg_rdata             <= next_rdata;
      irq                   <= next_irq;
    end
  end

  // ****************************************
  // Mode, limit and indicator logic
  // ****************************************
  logic       next_charge;
  logic       next_boost;
  logic       next_good;
  logic       next_charging;
  logic [2:0] pin_limit;
  logic [2:0] next_limit;
  logic       prev_charging;
  logic       prev_good;
  logic       prev_fault;

  // Mode gating, input limit selection and the change events that feed the interrupt logic.
  always_comb begin
    next_boost = control_register_1[`CPL_BOOST_BIT] && boost_request_pin
                 && !thermistor_sense_fault;
    next_charge = (control_register_1[`CPL_CFG_HI:`CPL_CFG_LO] == `CPL_CFG_CHARGE)
                  && !charge_enable_n && !thermistor_sense_fault;
    if (source_is_usb_host && !next_boost) begin
      pin_limit = boost_request_pin ? `CPL_LIM_500MA : `CPL_LIM_100MA;
    end else if (input_limit_resistor_pin < `CPL_LIM_500MA) begin
      pin_limit = `CPL_LIM_500MA;
    end else begin
      pin_limit = input_limit_resistor_pin;
    end
    // Every limit code lies above 30 mA, so the limit term of input-good is always met.
    next_limit = (pin_limit < input_source_register[`CPL_LIM_HI:`CPL_LIM_LO]) ? pin_limit
                 : input_source_register[`CPL_LIM_HI:`CPL_LIM_LO];
    next_good     = input_in_window && input_above_sleep && !next_boost;
    next_charging = next_charge && !charge_complete;
    events = '0;
    events[`CPL_INT_CHG]   = (next_charging != prev_charging) || (next_good != prev_good);
    events[`CPL_INT_FAULT] = fault_present && !prev_fault;
    events[`CPL_INT_SHIP]  = (ship_state == CPL_SHIP) && exit_done;
    events[`CPL_INT_RESET] = (ship_state == CPL_RUN) && hold_done && !input_present;
  end

  // Mode outputs and the previous values used for change detection.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      charge_enable       <= 1'b0;
      boost_enable        <= 1'b0;
      input_current_limit <= `CPL_LIM_100MA;
      input_good_n_oe     <= 1'b0;
      prev_charging       <= 1'b0;
      prev_good           <= 1'b0;
      prev_fault          <= 1'b0;
    end else if (clk_en) begin
      charge_enable       <= next_charge;
      boost_enable        <= next_boost;
      input_current_limit <= next_limit;
      input_good_n_oe     <= next_good;
      prev_charging       <= next_charging;
      prev_good           <= next_good;
      prev_fault          <= fault_present;
    end
  end

  // ****************************************
  // Interrupt pulse and fault blink
  // ****************************************
  logic [PW-1:0] next_pulse_cnt;
  logic [BW-1:0] blink_cnt;
  logic [BW-1:0] next_blink_cnt;
  logic          next_blink_phase;
  logic          next_status_oe;

  // One pulse per burst: events during a running pulse are kept in the status flags, not extended.
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - PW'(1);
    end else if (|events) begin
      next_pulse_cnt = PW'(IRQ_PULSE_CYCLES);
    end
    next_blink_cnt   = BW'(BLINK_HALF_CYCLES - 1); // Parked one step before a flip, so a fault opens a full half.
    next_blink_phase = 1'b0;
    if (fault_present) begin
      next_blink_phase = blink_phase;
      next_blink_cnt   = blink_cnt + BW'(1);
      if (blink_cnt == BW'(BLINK_HALF_CYCLES - 1)) begin
        next_blink_cnt   = '0;
        next_blink_phase = !blink_phase;
      end
    end
    next_status_oe = fault_present ? next_blink_phase : next_charging;
  end

  // Pulse and blink registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt          <= '0;
      interrupt_n_oe     <= 1'b0;
      blink_cnt          <= BW'(BLINK_HALF_CYCLES - 1);
      blink_phase        <= 1'b0;
      charge_status_n_oe <= 1'b0;
    end else if (clk_en) begin
      pulse_cnt          <= next_pulse_cnt;
      interrupt_n_oe     <= (next_pulse_cnt != '0);
      blink_cnt          <= next_blink_cnt;
      blink_phase        <= next_blink_phase;
      charge_status_n_oe <= next_status_oe;
    end
  end

  // ****************************************
  // Ship mode and system reset
  // ****************************************
  cpl_ship_state_type next_ship_state;
  logic [OW-1:0]      off_cnt;
  logic [OW-1:0]      next_off_cnt;

  // Short press leaves shipping mode; a long press is only acted on without input power.
  cpl_low_hold_timer #(.HOLD_CYCLES(DEGLITCH_CYCLES)) u_exit_deglitch (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .level_n   (ship_exit_button_n),
    .hold_done (exit_done)
  );

  cpl_low_hold_timer #(.HOLD_CYCLES(RESET_HOLD_CYCLES)) u_reset_hold (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .level_n   (ship_exit_button_n),
    .hold_done (hold_done)
  );

  // Battery switch sequencing.
  always_comb begin
    next_ship_state = ship_state;
    next_off_cnt    = '0;
    unique case (ship_state)
      CPL_RUN: begin
        if (ship_req) begin
          next_ship_state = CPL_SHIP;
        end else if (hold_done && !input_present) begin
          next_ship_state = CPL_RESET_OFF;
        end
      end
      CPL_SHIP: begin
        if (exit_done) begin
          next_ship_state = CPL_RUN;
        end
      end
      CPL_RESET_OFF: begin
        next_off_cnt = off_cnt + OW'(1);
        if (off_cnt == OW'(RESET_OFF_CYCLES - 1)) begin
          next_ship_state = CPL_RUN;
          next_off_cnt    = '0;
        end
      end
      default: next_ship_state = CPL_RUN;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ship_state        <= CPL_RUN;
      off_cnt           <= '0;
      battery_switch_on <= 1'b1;
    end else if (clk_en) begin
      ship_state        <= next_ship_state;
      off_cnt           <= next_off_cnt;
      battery_switch_on <= (next_ship_state == CPL_RUN);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_GOOD_DROP: assert property (clk_en && !(input_in_window && input_above_sleep) |=> !input_good_n_oe)
    else $error("Input-good driven with input outside its window.");
  AST_STATUS_CHG: assert property (clk_en && !fault_present && next_charging |=> charge_status_n_oe)
    else $error("Charge-status not low while charging.");
  AST_BLINK_HOLD: assert property (clk_en && fault_present && blink_cnt != BW'(BLINK_HALF_CYCLES - 1)
                                   |=> blink_phase == $past(blink_phase))
    else $error("Blink phase changed before half period.");
  AST_BLINK_FLIP: assert property (clk_en && fault_present && blink_cnt == BW'(BLINK_HALF_CYCLES - 1)
                                   |=> blink_phase != $past(blink_phase))
    else $error("Blink phase did not toggle at half period.");
  AST_IRQ_START: assert property ($rose(interrupt_n_oe) |-> pulse_cnt == PW'(IRQ_PULSE_CYCLES))
    else $error("Interrupt pulse started with wrong length.");
  AST_USB_LOW: assert property (clk_en && source_is_usb_host && !next_boost && !boost_request_pin
                                |=> input_current_limit == `CPL_LIM_100MA)
    else $error("USB host limit not 100 mA with boost pin low.");
  AST_BOOST_CAUSE: assert property ($rose(boost_enable)
                                    |-> $past(control_register_1[`CPL_BOOST_BIT] && boost_request_pin))
    else $error("Boost entered without bit and pin.");
  AST_CHARGE_CAUSE: assert property ($rose(charge_enable) |-> $past(!charge_enable_n
                                     && control_register_1[`CPL_CFG_HI:`CPL_CFG_LO] == `CPL_CFG_CHARGE))
    else $error("Charging enabled without config 01 and pin low.");
  AST_LIMIT_MIN: assert property (clk_en |=> input_current_limit <= $past(input_source_register[2:0]))
    else $error("Input limit above register field.");
  AST_RES_FLOOR: assert property (clk_en && !source_is_usb_host && input_source_register[2:0] >= `CPL_LIM_500MA
                                  |=> input_current_limit >= `CPL_LIM_500MA)
    else $error("Resistor limit taken below 500 mA.");
  AST_THERM: assert property (clk_en && thermistor_sense_fault |=> !charge_enable && !boost_enable)
    else $error("Thermistor fault did not stop charge or boost.");
  AST_SHIP_EXIT: assert property (clk_en && ship_state == CPL_SHIP && exit_done |=> battery_switch_on)
    else $error("Ship exit did not turn the battery switch on.");
  AST_RESET_OFF: assert property (clk_en && ship_state == CPL_RUN && hold_done && !input_present && !ship_req
                                  |=> !battery_switch_on ##0 off_cnt == '0)
    else $error("Long press did not start the off period.");

  COV_IRQ: cover property ($rose(interrupt_n_oe));
  COV_BLINK: cover property (clk_en && fault_present && blink_cnt == BW'(BLINK_HALF_CYCLES - 1));
  COV_SHIP: cover property (ship_state == CPL_SHIP ##1 ship_state == CPL_RUN);
  COV_BOOST: cover property ($rose(boost_enable));

endmodule

// ---- test/cpl_host_model.sv ----
// Behavioural host processor and source detector that sit on the charger's pins.
`timescale 1ns/1ns
module cpl_host_model (
  input  wire logic want_usb,
  input  wire logic want_boost,
  input  wire logic want_charge,
  input  wire logic press,
  input  wire logic input_good_n_oe,
  input  wire logic charge_status_n_oe,
  input  wire logic interrupt_n_oe,
  output logic      source_is_usb_host,
  output logic      boost_request_pin,
  output logic      charge_enable_n,
  output logic      ship_exit_button_n,
  output logic      input_good_n,
  output logic      charge_status_n,
  output logic      interrupt_n
);
  // The detector drives high for a host port and low for a wall adapter.
  assign source_is_usb_host = want_usb;
  assign boost_request_pin  = want_boost;
  // The enable pin is always driven one way, never left floating.
  assign charge_enable_n    = ~want_charge;
  // The button line idles high through its pull-up when nobody presses.
  assign ship_exit_button_n = ~press;
  // Open-drain lines float up to the pull-up rail unless the charger sinks them.
  assign input_good_n       = input_good_n_oe ? 1'b0 : 1'b1;
  assign charge_status_n    = charge_status_n_oe ? 1'b0 : 1'b1;
  assign interrupt_n        = interrupt_n_oe ? 1'b0 : 1'b1;
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the charger pin logic.
`timescale 1ns/1ns
module tb;
  import cpl_pkg::*;
  logic        mclk, rst_n, clk_en, reg_write, reg_read, in_win, in_slp, in_pres, therm, done, fault, taken;
  logic        want_usb, want_boost, want_chg, press, usb_p, boost_p, ce_n, btn_n, good_n, stat_n, int_n;
  logic        good_oe, stat_oe, int_oe, irq, chg_en, boost_en, batt_on;
  logic [2:0]  reg_addr, res_pin, lim, e;
  logic [7:0]  reg_wdata, reg_rdata, rnd;
  logic [15:0] exp_q[$];
  logic [15:0] n_e;
  int          num_errors, check_count, n, m;

  cpl_host_model host_u (.want_usb(want_usb), .want_boost(want_boost), .want_charge(want_chg), .press(press),
    .input_good_n_oe(good_oe), .charge_status_n_oe(stat_oe), .interrupt_n_oe(int_oe),
    .source_is_usb_host(usb_p), .boost_request_pin(boost_p), .charge_enable_n(ce_n),
    .ship_exit_button_n(btn_n), .input_good_n(good_n), .charge_status_n(stat_n), .interrupt_n(int_n));

  // Short counts keep every timer visible within a few dozen cycles.
  cpl_charger_pins #(.IRQ_PULSE_CYCLES(8), .BLINK_HALF_CYCLES(4), .DEGLITCH_CYCLES(5),
    .RESET_HOLD_CYCLES(20), .RESET_OFF_CYCLES(6)) dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .source_is_usb_host(usb_p), .boost_request_pin(boost_p), .charge_enable_n(ce_n),
    .input_limit_resistor_pin(res_pin), .input_in_window(in_win), .input_above_sleep(in_slp),
    .input_present(in_pres), .thermistor_sense_fault(therm), .charge_complete(done), .fault_present(fault),
    .ship_exit_button_n(btn_n), .input_good_n_oe(good_oe), .charge_status_n_oe(stat_oe),
    .interrupt_n_oe(int_oe), .irq(irq), .charge_enable(chg_en), .boost_enable(boost_en),
    .input_current_limit(lim), .battery_switch_on(batt_on));

  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each bus task starts on a fresh edge, so a strobe is never raised and dropped in one time step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] care);
    @(posedge mclk);
    exp_q.push_back({care, d});
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
  always @(posedge mclk) taken <= reg_read & clk_en & rst_n;
  always @(negedge mclk) begin
    if (taken) begin
      if (exp_q.size() == 0) check("rdata_extra", 8'h00, 8'h01);
      else begin
        n_e = exp_q.pop_front();
        check("rdata", reg_rdata & n_e[15:8], n_e[7:0] & n_e[15:8]);
      end
    end
  end

  // Main sequence: reset, registers, modes, limits, faults, then the ship-exit button.
  initial begin
    {rst_n, reg_write, reg_read, in_win, in_slp, in_pres, therm, done, fault} = '0;
    {want_usb, want_boost, want_chg, press, reg_addr, reg_wdata, res_pin} = '0;
    clk_en = 1'b1;
    num_errors = 0;
    check_count = 0;
    rnd = 8'h0B;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(3'h0, 8'h02, 8'hFF);
    rd(3'h1, 8'h10, 8'hFF);
    rd(3'h3, 8'h0F, 8'hFF);
    rd(3'h5, 8'h04, 8'hFF);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    clk_en <= 1'b0;
    wr(3'h1, 8'h00);
    clk_en <= 1'b1;
    rd(3'h1, 8'h10, 8'hFF);
    @(posedge mclk);
    {in_win, in_slp, in_pres, want_chg} <= 4'hF;
    settle();
    check("charge_en", chg_en, 1'b1);
    check("good_n", good_n, 1'b0);
    check("stat_n", stat_n, 1'b0);
    @(posedge mclk);
    done <= 1'b1;
    settle();
    check("stat_done", stat_oe, 1'b0);
    @(posedge mclk);
    {done, want_chg} <= 2'b00;
    settle();
    check("charge_pin_off", chg_en, 1'b0);
    check("stat_off", stat_oe, 1'b0);
    @(posedge mclk);
    want_chg <= 1'b1;
    wr(3'h1, 8'h00);
    settle();
    check("charge_cfg_off", chg_en, 1'b0);
    wr(3'h1, 8'h10);
    @(posedge mclk);
    therm <= 1'b1;
    settle();
    check("charge_therm", chg_en, 1'b0);
    @(posedge mclk);
    {therm, in_win} <= 2'b00;
    settle();
    check("good_window", good_oe, 1'b0);
    @(posedge mclk);
    in_win <= 1'b1;
    want_boost <= 1'b1;
    wr(3'h1, 8'h20);
    settle();
    check("boost_on", boost_en, 1'b1);
    @(posedge mclk);
    therm <= 1'b1;
    settle();
    check("boost_therm", boost_en, 1'b0);
    @(posedge mclk);
    {therm, want_boost} <= 2'b00;
    settle();
    check("boost_pin_low", boost_en, 1'b0);
    wr(3'h1, 8'h10);
    wr(3'h0, 8'h07);
    for (n = 0; n < 2; n++) begin
      @(posedge mclk);
      want_usb <= 1'b1;
      want_boost <= n[0];
      settle();
      check("usb_limit", lim, n[0] ? 3'h2 : 3'h0);
    end
    @(posedge mclk);
    {want_usb, want_boost} <= 2'b00;
    // Random resistor and register codes; the resistor side is floored before the lower one wins.
    for (n = 0; n < 12; n++) begin
      rnd = lfsr(rnd);
      res_pin <= rnd[2:0];
      wr(3'h0, {5'h00, rnd[5:3]});
      e = (rnd[2:0] < 3'h2) ? 3'h2 : rnd[2:0];
      if (rnd[5:3] < e) e = rnd[5:3];
      settle();
      check("min_limit", lim, e);
    end
    rd(3'h2, 8'h00, 8'h00);
    @(posedge mclk);
    done <= 1'b1;
    // The charging flag fell, so the interrupt pulses now; let it run out before the fault rises.
    settle();
    check("int_chg", int_n, 1'b0);
    repeat (10) @(posedge mclk);
    fault <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 16; n++) begin
      @(negedge mclk);
      check("int_n", int_n, (n < 8) ? 1'b0 : 1'b1);
      check("blink", stat_oe, ((n / 4) % 2 == 0) ? 1'b1 : 1'b0);
    end
    check("irq_on", irq, 1'b1);
    wr(3'h3, 8'h00);
    settle();
    check("irq_masked", irq, 1'b0);
    wr(3'h3, 8'h0F);
    rd(3'h2, 8'h02, 8'h02);
    settle();
    check("irq_cleared", irq, 1'b0);
    @(posedge mclk);
    fault <= 1'b0;
    settle();
    for (n = 0; n < 8; n++) begin
      @(negedge mclk);
      check("blink_end", stat_oe, 1'b0);
    end
    wr(3'h4, 8'h01);
    settle();
    check("ship_off", batt_on, 1'b0);
    @(posedge mclk);
    press <= 1'b1;
    repeat (3) @(posedge mclk);
    press <= 1'b0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check("ship_glitch", batt_on, 1'b0);
    @(posedge mclk);
    press <= 1'b1;
    repeat (10) @(posedge mclk);
    press <= 1'b0;
    settle();
    check("ship_exit", batt_on, 1'b1);
    @(posedge mclk);
    in_pres <= 1'b0;
    settle();
    @(posedge mclk);
    press <= 1'b1;
    n = 0;
    while (batt_on !== 1'b0 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check("hold_long", (n >= 20 && n < 60) ? 1'b1 : 1'b0, 1'b1);
    @(posedge mclk);
    press <= 1'b0;
    m = 1;
    @(negedge mclk);
    while (batt_on !== 1'b1 && m < 30) begin
      m++;
      @(negedge mclk);
    end
    check("off_time", m[7:0], 8'h06);
    rd(3'h2, 8'h0C, 8'h0C);
    settle();
    check("queue_empty", exp_q.size() == 0, 1'b1);
    wrap_up();
  end
endmodule
